// File: shared/vdrd_pkg.sv
/*
  Constants and carrier types for the blanking-interval data request decoder.
  Assumes a 250 MHz system clock and an upstream front end that supplies line
  numbers, sliced data bits and decoded video samples.
*/
package vdrd_pkg;
  // Clock period in nanoseconds.
  localparam int CLK_NS = 4;
  // Register index of the request register on the write port.
  localparam logic [3:0] REG_IDX_REQUEST = 4'h0;
  // Reset values of request bits and completion flags.
  localparam logic [4:0] REQ_RESET = 5'h00;
  localparam logic [4:0] DONE_RESET = 5'h1F;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  // Lines that carry each kind of data.
  localparam logic [9:0] LN_CAPTION = 10'd21;
  localparam logic [9:0] LN_EXTENDED = 10'd284;
  localparam logic [9:0] LN_COPY_F1 = 10'd20;
  localparam logic [9:0] LN_COPY_F2_525 = 10'd283;
  localparam logic [9:0] LN_COPY_F2_625 = 10'd333;
  localparam logic [9:0] LN_WIDE = 10'd23;
  localparam logic [9:0] LN_ASPECT_F1 = 10'd16;
  localparam logic [9:0] LN_ASPECT_F2 = 10'd279;
  // Number of sliced bits that make one complete word.
  localparam logic [4:0] NB_CAPTION = 5'd16;
  localparam logic [4:0] NB_COPY = 5'd14;
  localparam logic [4:0] NB_WIDE = 5'd14;
  // Blanking line bounds for the 625-line system.
  localparam logic [9:0] LN_625_F1_OPEN = 10'd6;
  localparam logic [9:0] LN_625_F2_START = 10'd311;
  localparam logic [9:0] LN_625_F2_OPEN = 10'd318;
  localparam logic [9:0] LN_625_TAIL = 10'd624;
  localparam logic [9:0] BLANK_F1_BACKOFF = 10'd2;
  // Blanking output codes.
  localparam logic [7:0] Y_BLACK = 8'h10;
  localparam logic [7:0] C_NEUTRAL = 8'h80;
  // Aspect pulse timing, from the sync edge.
  localparam int ASP_RISE_NS = 12500;
  localparam int ASP_TOL_NS = 3200;
  localparam logic [11:0] ASP_MIN_CYC = 12'((ASP_RISE_NS - ASP_TOL_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [11:0] ASP_MAX_CYC = 12'((ASP_RISE_NS + ASP_TOL_NS) / CLK_NS);
  // Aspect pulse amplitude window in IRE, mapped onto luma codes.
  localparam int ASP_LVL_IRE = 70;
  localparam int ASP_TOL_IRE = 25;
  localparam int CODE_PER_100_IRE = 219;
  localparam logic [7:0] ASP_LO_CODE =
    8'(16 + (ASP_LVL_IRE - ASP_TOL_IRE) * CODE_PER_100_IRE / 100);
  localparam logic [7:0] ASP_HI_CODE =
    8'(16 + (ASP_LVL_IRE + ASP_TOL_IRE) * CODE_PER_100_IRE / 100);

  // One video sample: luma and multiplexed chroma.
  typedef struct packed {
    logic [7:0] y;
    logic [7:0] c;
  } vdrd_pix_t;

  // One bit per data kind, in request register order (bit 4 down to bit 0).
  typedef struct packed {
    logic wide;
    logic copy;
    logic extended;
    logic caption;
    logic aspect;
  } vdrd_req_t;
endpackage

// File: hdl/vdrd_decoder.sv
/*
  Blanking-interval data request decoder: host requests, line capture of
  sliced bits, aspect pulse detection, data registers and 625-line blanking
  output codes.
  Assumes line_start pulses once per line at the sync 50 percent edge with
  line_number valid, and that sliced bits arrive in transmission order.
*/
`timescale 1ns/1ps
// Function
// - Caption request waits, decodes, sets done.
// - Caption done is one after reset, cleared by request.
// - Caption word held, low byte first.
// - Extended request waits, decodes, sets done.
// - Extended done one after reset, cleared by request.
// - Extended word held, low byte first.
// - Copy request waits, decodes, sets done.
// - Copy done one after reset, cleared by request.
// - Copy word split across two registers reversed.
// - Wide request waits, sets done, clears on request.
// - Wide bits 0-7 low, 8-13 high.
// - Aspect request detects pulse, stores bit seven.
// - Aspect bit zero normal, one wide, held.
// - Aspect pulse level 70 plus minus 25 IRE.
// - Aspect rising edge 12.5 plus minus 3.2 us.
// - Caption taken from line 21.
// - Extended data taken from line 284.
// - Copy data lines 20 and 283 or 333.
// - Wide signalling only 625-line, line 23.
// - 625 blanking outputs black or passed luma.
// - Aspect request on 625 component is ignored.
module vdrd_decoder (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic reg_wr_en,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic line_start,
  input wire logic [9:0] line_number,
  input wire logic system_625,
  input wire logic component_input,
  input wire logic slice_bit_valid,
  input wire logic slice_bit,
  input wire vdrd_pkg::vdrd_pix_t video_in,
  input wire logic protect_state_hi,
  input wire logic protect_state_lo,
  input wire logic vbi_passthrough_sel,
  input wire logic [4:0] blanking_length,
  output logic [7:0] vbi_request,
  output logic [7:0] decode_status_two,
  output logic [7:0] caption_low_byte,
  output logic [7:0] caption_high_byte,
  output logic [7:0] extended_low_byte,
  output logic [7:0] extended_high_byte,
  output logic [7:0] copy_gen_upper,
  output logic [7:0] copy_gen_lower,
  output logic [7:0] widescreen_low,
  output logic [7:0] widescreen_high_aspect,
  output vdrd_pkg::vdrd_pix_t video_out
);

  // Reverses the order of six bits; copy-generation bits land MSB-first.
  function automatic logic [5:0] rev6(input logic [5:0] v);
    rev6 = {v[0], v[1], v[2], v[3], v[4], v[5]};
  endfunction

  // Reverses the order of eight bits.
  function automatic logic [7:0] rev8(input logic [7:0] v);
    rev8 = {v[0], v[1], v[2], v[3], v[4], v[5], v[6], v[7]};
  endfunction

  vdrd_pkg::vdrd_req_t req;
  vdrd_pkg::vdrd_req_t done;
  vdrd_pkg::vdrd_req_t wr_one;
  vdrd_pkg::vdrd_req_t set_done;
  logic [9:0] cur_line;
  logic [15:0] cap_bits;
  logic [4:0] bit_cnt;
  logic [11:0] pos_cnt;
  logic prev_band;
  logic pulse_seen;
  logic aspect_bit;
  logic [9:0] next_cur_line;

  // All events are gated by the clock enable so a frozen block sees nothing.
  wire req_write = clk_en & reg_wr_en & (reg_addr == vdrd_pkg::REG_IDX_REQUEST);
  wire line_go = clk_en & line_start;
  wire bit_go = clk_en & slice_bit_valid & (bit_cnt < vdrd_pkg::NB_CAPTION);
  assign wr_one = req_write ? vdrd_pkg::vdrd_req_t'(reg_wdata[4:0]) : vdrd_pkg::REQ_RESET;

  // Line matching for each data kind, evaluated on the line that just ended.
  // caption line match
  wire on_caption = !system_625 && (cur_line == vdrd_pkg::LN_CAPTION);
  wire on_extended = !system_625 && (cur_line == vdrd_pkg::LN_EXTENDED);
  wire on_copy = (cur_line == vdrd_pkg::LN_COPY_F1) ||
                 (!system_625 && cur_line == vdrd_pkg::LN_COPY_F2_525) ||
                 (system_625 && cur_line == vdrd_pkg::LN_COPY_F2_625);
  wire on_wide = system_625 && (cur_line == vdrd_pkg::LN_WIDE);
  wire on_aspect = (cur_line == vdrd_pkg::LN_ASPECT_F1) ||
                   (cur_line == vdrd_pkg::LN_ASPECT_F2);
  // 625 component input never decodes aspect
  wire aspect_blocked = system_625 && component_input;

  // Each decode but aspect completes at the end of its line when the bit count, which stops at 16, equals its word's bit count.
  // caption completion
  assign set_done.caption = line_go && req.caption && on_caption &&
                            (bit_cnt == vdrd_pkg::NB_CAPTION);
  assign set_done.extended = line_go && req.extended && on_extended &&
                             (bit_cnt == vdrd_pkg::NB_CAPTION);
  assign set_done.copy = line_go && req.copy && on_copy && (bit_cnt == vdrd_pkg::NB_COPY);
  assign set_done.wide = line_go && req.wide && on_wide && (bit_cnt == vdrd_pkg::NB_WIDE);
  // aspect completion at end of line 16 or 279
  assign set_done.aspect = line_go && req.aspect && on_aspect && !aspect_blocked;

  // Aspect pulse detection: amplitude band and rising edge timing window.
  // amplitude band check
  wire in_band = (video_in.y >= vdrd_pkg::ASP_LO_CODE) && (video_in.y <= vdrd_pkg::ASP_HI_CODE);
  wire in_window = (pos_cnt >= vdrd_pkg::ASP_MIN_CYC) && (pos_cnt <= vdrd_pkg::ASP_MAX_CYC);
  wire rise_hit = clk_en && in_band && !prev_band && in_window;
  wire pos_max = (pos_cnt == 12'hFFF);

  // 625-line blanking region decode, resolved to whole lines.
  wire [9:0] bl_line = {5'h00, blanking_length};
  wire fixed_black = (line_number < vdrd_pkg::LN_625_F1_OPEN) ||
                     (line_number >= vdrd_pkg::LN_625_TAIL) ||
                     ((line_number >= vdrd_pkg::LN_625_F2_START) &&
                      (line_number < vdrd_pkg::LN_625_F2_OPEN));
  wire open_blank = ((line_number >= vdrd_pkg::LN_625_F1_OPEN) &&
                     (line_number + vdrd_pkg::BLANK_F1_BACKOFF <= bl_line)) ||
                    ((line_number >= vdrd_pkg::LN_625_F2_OPEN) &&
                     (line_number < vdrd_pkg::LN_625_F2_START + bl_line));
  wire force_black = system_625 && (fixed_black || (open_blank && !vbi_passthrough_sel));
  wire pass_luma = system_625 && !fixed_black && open_blank && vbi_passthrough_sel;
  assign next_cur_line = line_go ? line_number : cur_line;

  // Request bits: ones written set them, completion clears them.
  // auto clear on completion
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      req <= vdrd_pkg::REQ_RESET;
    end else begin
      req <= (req & ~set_done) | wr_one;
    end
  end

  // Completion flags: set wins over the clear caused by a new request.
  // done cleared by request write
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      done <= vdrd_pkg::DONE_RESET;
    end else begin
      done <= set_done | (done & ~wr_one);
    end
  end

  // Line tracking and serial bit capture; bit k lands in cap_bits[k].
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cur_line <= 10'h000;
      cap_bits <= 16'h0000;
      bit_cnt <= 5'h00;
    end else if (line_go) begin
      cur_line <= next_cur_line;
      bit_cnt <= 5'h00;
    end else if (bit_go) begin
      cap_bits[bit_cnt[3:0]] <= slice_bit;
      bit_cnt <= bit_cnt + 5'h01;
    end
  end

  // Position counter from the sync edge; saturates so long lines cannot wrap.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pos_cnt <= 12'h000;
      prev_band <= 1'b0;
      pulse_seen <= 1'b0;
    end else if (clk_en) begin
      pos_cnt <= line_start ? 12'h000 : (pos_max ? pos_cnt : pos_cnt + 12'h001);
      prev_band <= in_band;
      pulse_seen <= line_start ? 1'b0 : (pulse_seen | rise_hit);
    end
  end

  // Data registers: written only on completion, otherwise held.
  // caption word low byte first
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      caption_low_byte <= vdrd_pkg::BYTE_ZERO;
      caption_high_byte <= vdrd_pkg::BYTE_ZERO;
    end else if (set_done.caption) begin
      caption_low_byte <= cap_bits[7:0];
      caption_high_byte <= cap_bits[15:8];
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      extended_low_byte <= vdrd_pkg::BYTE_ZERO;
      extended_high_byte <= vdrd_pkg::BYTE_ZERO;
    end else if (set_done.extended) begin
      extended_low_byte <= cap_bits[7:0];
      extended_high_byte <= cap_bits[15:8];
    end
  end

  // Copy word bit n arrives as cap_bits[n-1]; the earliest bit sits highest.
  // copy word bit placement
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      copy_gen_upper <= vdrd_pkg::BYTE_ZERO;
      copy_gen_lower <= vdrd_pkg::BYTE_ZERO;
    end else if (set_done.copy) begin
      copy_gen_upper <= rev8(cap_bits[13:6]);
      copy_gen_lower <= {2'b00, rev6(cap_bits[5:0])};
    end
  end

  // Wide signalling and aspect share the high register; each updates its own bits.
  // wide bit placement
  // aspect bit held until next decode
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      widescreen_low <= vdrd_pkg::BYTE_ZERO;
      widescreen_high_aspect <= vdrd_pkg::BYTE_ZERO;
      aspect_bit <= 1'b0;
    end else begin
      if (set_done.wide) begin
        widescreen_low <= cap_bits[7:0];
      end
      if (set_done.aspect) begin
        aspect_bit <= pulse_seen;
      end
      widescreen_high_aspect <= {set_done.aspect ? pulse_seen : aspect_bit, 1'b0,
        set_done.wide ? cap_bits[13:8] : widescreen_high_aspect[5:0]};
    end
  end

  // Register images of request and status; request upper bits read as zero, status bits 7 and 6 carry the protect states.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      vbi_request <= vdrd_pkg::BYTE_ZERO;
      decode_status_two <= {3'b000, vdrd_pkg::DONE_RESET};
    end else if (clk_en) begin
      vbi_request <= {3'b000, (req & ~set_done) | wr_one};
      decode_status_two <= {protect_state_hi, protect_state_lo, 1'b0,
                            set_done | (done & ~wr_one)};
    end
  end

  // Video output: blanking codes in the 625 interval, else the decoded sample.
  // blanking output codes
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      video_out <= '{y: vdrd_pkg::Y_BLACK, c: vdrd_pkg::C_NEUTRAL};
    end else if (clk_en) begin
      video_out.y <= force_black ? vdrd_pkg::Y_BLACK : video_in.y;
      video_out.c <= (force_black || pass_luma) ? vdrd_pkg::C_NEUTRAL : video_in.c;
    end
  end

  // Checks that run beside the logic.
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  sequence s_cap_request;
    wr_one.caption && !set_done.caption;
  endsequence

  sequence s_cap_line_end;
    line_go && req.caption && on_caption && (bit_cnt == vdrd_pkg::NB_CAPTION);
  endsequence

  a_caption_request_clear: assert property (
    s_cap_request |=> !decode_status_two[1] && vbi_request[1])
    else $error("caption done not cleared by request");

  // A request written in the completion cycle keeps its bit, so compare with that write.
  a_caption_done_set: assert property (
    s_cap_line_end |=> decode_status_two[1] && (vbi_request[1] == $past(wr_one.caption)))
    else $error("caption completion not flagged");

  a_caption_data_held: assert property (
    !set_done.caption |=> $stable(caption_low_byte) && $stable(caption_high_byte))
    else $error("caption data changed without decode");

  a_ext_store_order: assert property (
    set_done.extended |=> extended_high_byte == $past(cap_bits[15:8]) &&
                          extended_low_byte == $past(cap_bits[7:0]))
    else $error("extended bytes misplaced");

  a_copy_bit_order: assert property (
    set_done.copy |=> copy_gen_lower[5] == $past(cap_bits[0]) &&
                      copy_gen_upper[0] == $past(cap_bits[13]) &&
                      copy_gen_lower[7:6] == 2'b00)
    else $error("copy word bits misplaced");

  a_wide_only_625: assert property (
    set_done.wide |-> system_625 && cur_line == vdrd_pkg::LN_WIDE)
    else $error("wide decode outside 625 line 23");

  a_aspect_blocked_stay: assert property (
    req.aspect && aspect_blocked |-> !set_done.aspect ##1 req.aspect)
    else $error("aspect request not kept on 625 component");

  a_aspect_window_low: assert property (
    rise_hit |-> pos_cnt >= 12'd2325 && pos_cnt <= 12'd3925)
    else $error("aspect edge accepted outside window");

  a_blank_black_code: assert property (
    clk_en && force_black |=> video_out.y == 8'h10 && video_out.c == 8'h80)
    else $error("blanking code wrong");

  a_done_reqs_clear: assert property (
    set_done.copy && !wr_one.copy |=> !req.copy ##1 (!req.copy || $past(wr_one.copy)))
    else $error("copy request not cleared on done");

  // Each remaining request write clears its own flag one cycle later.
  a_ext_request_clear: assert property (
    wr_one.extended && !set_done.extended |=> !decode_status_two[2] && vbi_request[2])
    else $error("extended done not cleared by request");

  a_copy_request_clear: assert property (
    wr_one.copy && !set_done.copy |=> !decode_status_two[3] && vbi_request[3])
    else $error("copy done not cleared by request");

  a_wide_request_clear: assert property (
    wr_one.wide && !set_done.wide |=> !decode_status_two[4] && vbi_request[4])
    else $error("wide done not cleared by request");

  a_caption_store_order: assert property (
    set_done.caption |=> caption_low_byte == $past(cap_bits[7:0]) &&
                         caption_high_byte == $past(cap_bits[15:8]))
    else $error("caption bytes misplaced");

  a_wide_bit_place: assert property (
    set_done.wide |=> widescreen_low == $past(cap_bits[7:0]) &&
                      widescreen_high_aspect[5:0] == $past(cap_bits[13:8]) &&
                      !widescreen_high_aspect[6])
    else $error("wide bits misplaced");

  a_aspect_bit_store: assert property (
    set_done.aspect |=> widescreen_high_aspect[7] == $past(pulse_seen) &&
                        decode_status_two[0])
    else $error("aspect result not stored");

  a_aspect_bit_held: assert property (
    !set_done.aspect |=> $stable(widescreen_high_aspect[7]))
    else $error("aspect bit changed without decode");

  // Line numbers are written out here so a wrong package constant shows up.
  a_caption_line_match: assert property (
    set_done.caption |-> !system_625 && cur_line == 10'h015)
    else $error("caption decoded on wrong line");

  a_ext_line_match: assert property (
    set_done.extended |-> !system_625 && cur_line == 10'h11C)
    else $error("extended data decoded on wrong line");

  a_copy_line_match: assert property (
    set_done.copy |-> cur_line == 10'h014 || cur_line == (system_625 ? 10'h14D : 10'h11B))
    else $error("copy data decoded on wrong line");

  a_aspect_level_band: assert property (
    rise_hit |-> video_in.y >= 8'h72 && video_in.y <= 8'hE0)
    else $error("aspect edge accepted outside level band");

  a_blank_pass_luma: assert property (
    clk_en && pass_luma |=> video_out.y == $past(video_in.y) && video_out.c == 8'h80)
    else $error("passed blanking line wrong");

endmodule // vdrd_decoder

// File: verif/vdrd_front_model.sv
/*
  Front-end model: drives line starts, sliced bits and video samples, and
  notes the expected video output of every sample it drives.
  Assumes the bench calls run_line and feeds a new random byte each cycle.
*/
`timescale 1ns/1ps
module vdrd_front_model (
  input wire logic sys_clk,
  input wire logic system_625,
  input wire logic vbi_passthrough_sel,
  input wire logic [4:0] blanking_length,
  input wire logic [7:0] rand_y,
  output logic line_start,
  output logic [9:0] line_number,
  output logic slice_bit_valid,
  output logic slice_bit,
  output vdrd_pkg::vdrd_pix_t video_in
);
  vdrd_pkg::vdrd_pix_t vexp[$];

  // Quiet levels until the first line begins.
  initial begin
    line_start = 1'b0;
    line_number = 10'h000;
    slice_bit_valid = 1'b0;
    slice_bit = 1'b0;
    video_in = 16'h1080;
  end

  function automatic vdrd_pkg::vdrd_pix_t blank(input logic [9:0] ln,
                                                input vdrd_pkg::vdrd_pix_t p);
    logic [9:0] bl;
    bl = 10'(blanking_length);
    if (!system_625) return p;
    if (ln < 10'h006 || ln >= 10'h270 || (ln >= 10'h137 && ln <= 10'h13D)) return 16'h1080;
    if ((ln >= 10'h006 && ln + 10'h002 <= bl) || (ln >= 10'h13E && ln <= bl + 10'h136))
      return {vbi_passthrough_sel ? p.y : 8'h10, 8'h80};
    return p;
  endfunction

  // One line; long lines carry a flat luma with an optional pulse, so no
  // random sample can fake an aspect edge. The data line toggles when idle.
  task automatic run_line(input logic [9:0] ln, input logic [15:0] w, input int nb,
                          input int len, input int pos, input logic [7:0] lvl);
    vdrd_pkg::vdrd_pix_t p;
    for (int i = 0; i < len; i++) begin
      @(posedge sys_clk);
      p.c = rand_y;
      p.y = (len < 100) ? rand_y : ((i >= pos && i < pos + 40) ? lvl : 8'h20);
      line_start <= (i == 0);
      line_number <= ln;
      slice_bit_valid <= (i % 2 == 1) && (i / 2 < nb);
      slice_bit <= (i % 2 == 1) ? w[4'(i / 2)] : ~slice_bit;
      video_in <= p;
      vexp.push_back(blank(ln, p));
    end
  endtask
endmodule // vdrd_front_model

// File: verif/tb_vbi_data_request_decoder.sv
/*
  Self-checking bench: request writes, line traffic from the front-end model,
  expected states queued and matched whenever the registers change.
  Assumes the package, the decoder and the front-end model compile first.
*/
`timescale 1ns/1ps
module tb_vbi_data_request_decoder;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic clk_en = 1'b1;
  logic reg_wr_en = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic system_625 = 1'b0;
  logic component_input = 1'b0;
  logic protect_state_hi = 1'b0;
  logic protect_state_lo = 1'b0;
  logic vbi_passthrough_sel = 1'b0;
  logic [4:0] blanking_length = 5'h10;
  logic [7:0] rand_y = 8'h00;
  logic [31:0] seed = 32'hD828;
  logic line_start, slice_bit_valid, slice_bit, vvalid;
  logic [9:0] line_number, b;
  vdrd_pkg::vdrd_pix_t video_in, video_out, vhold;
  wire [9:0][7:0] snap;
  logic [9:0][7:0] shadow, last_seen, nx;
  logic [79:0] sq[$];
  logic [15:0] w;
  logic [1:0] r;
  logic [9:0] ll[13];
  logic [9:0] cl[3] = '{10'h014, 10'h11B, 10'h14D};
  logic [9:0] al[6] = '{10'h010, 10'h117, 10'h010, 10'h117, 10'h010, 10'h117};
  int ap[6] = '{3125, 2200, 3915, 3990, 3125, 2330};
  logic [7:0] av[6] = '{8'hA0, 8'hA0, 8'h72, 8'hA0, 8'hF0, 8'hE0};
  logic [5:0] ae = 6'h25;
  int err_total = 0;
  int checks_done = 0;

  // Clock of 4 ns and a fresh random byte each cycle for the model.
  always #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk) rand_y <= 8'(rnd());

  // Shift register with taps 32, 22, 2 and 1.
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction

  vdrd_decoder dut (
    .sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en), .reg_wr_en(reg_wr_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .line_start(line_start),
    .line_number(line_number), .system_625(system_625), .component_input(component_input),
    .slice_bit_valid(slice_bit_valid), .slice_bit(slice_bit), .video_in(video_in),
    .protect_state_hi(protect_state_hi), .protect_state_lo(protect_state_lo),
    .vbi_passthrough_sel(vbi_passthrough_sel), .blanking_length(blanking_length),
    .vbi_request(snap[9]), .decode_status_two(snap[8]), .caption_low_byte(snap[7]),
    .caption_high_byte(snap[6]), .extended_low_byte(snap[5]), .extended_high_byte(snap[4]),
    .copy_gen_upper(snap[3]), .copy_gen_lower(snap[2]), .widescreen_low(snap[1]),
    .widescreen_high_aspect(snap[0]), .video_out(video_out));

  vdrd_front_model fe (
    .sys_clk(sys_clk), .system_625(system_625), .vbi_passthrough_sel(vbi_passthrough_sel),
    .blanking_length(blanking_length), .rand_y(rand_y), .line_start(line_start),
    .line_number(line_number), .slice_bit_valid(slice_bit_valid), .slice_bit(slice_bit),
    .video_in(video_in));

  // Count a comparison and report a mismatch at once.
  task automatic check(input logic [79:0] got, input logic [79:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Queue a new expected state only when it differs, so queue and changes align.
  task automatic note(input logic [79:0] v);
    if (v !== shadow) sq.push_back(v);
    shadow = v;
  endtask

  // One write cycle; a non-last write leaves the strobe up for the next one.
  task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic en, input logic last);
    @(posedge sys_clk);
    clk_en <= en;
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr_en <= 1'b1;
    if (last) begin
      @(posedge sys_clk);
      reg_wr_en <= 1'b0;
      clk_en <= 1'b1;
    end
  endtask

  task automatic req(input logic [7:0] d, input logic last);
    nx = shadow;
    nx[9] = nx[9] | {3'h0, d[4:0]};
    nx[8] = nx[8] & ~{3'h0, d[4:0]};
    note(nx);
    wr(4'h0, d, 1'b1, last);
  endtask

  // Completion clears request, sets done and, when bi is above zero, loads the byte pair.
  function automatic logic [79:0] fin(input int k, input int bi, input logic [15:0] v);
    logic [9:0][7:0] e;
    e = shadow;
    e[9][k] = 1'b0;
    e[8][k] = 1'b1;
    if (bi > 0) begin
      e[bi] = v[15:8];
      e[bi - 1] = v[7:0];
    end
    return e;
  endfunction

  function automatic logic [15:0] copy_map(input logic [13:0] a);
    logic [15:0] v;
    v = 16'h0000;
    for (int j = 0; j < 6; j++) v[5 - j] = a[j];
    for (int j = 0; j < 8; j++) v[15 - j] = a[6 + j];
    return v;
  endfunction

  // Target line, then the next line start that closes the capture.
  task automatic cap(input logic [9:0] ln, input logic [15:0] d, input int nb, input int len,
                     input int pos, input logic [7:0] lvl, input logic [79:0] e);
    fe.run_line(ln, d, nb, len, pos, lvl);
    note(e);
    fe.run_line(ln + 10'h001, ~d, 0, 48, 0, 8'h20);
  endtask

  task automatic asp(input logic [9:0] ln, input int pos, input logic [7:0] lvl, input logic e);
    nx = fin(0, 0, 16'h0000);
    nx[0][7] = e;
    cap(ln, 16'h0000, 0, 4000, pos, lvl, nx);
  endtask

  // Registers change only as queued; video lags input by one cycle.
  always @(negedge sys_clk) begin
    if (reset_n) begin
      if (snap !== last_seen) begin
        check(snap, (sq.size() > 0) ? sq.pop_front() : last_seen);
        last_seen = snap;
      end
      if (vvalid) check(80'(video_out), 80'(vhold));
      vvalid = fe.vexp.size() > 0;
      if (vvalid) vhold = fe.vexp.pop_front();
    end
  end

  // Verdict and end of the run.
  task automatic final_report();
    if (err_total == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Cut a hung run short.
  initial begin
    repeat (100000) @(posedge sys_clk);
    check(80'h1, 80'h0);
    final_report();
  end

  initial begin
    vvalid = 1'b0;
    shadow = {8'h00, 8'h1F, 64'h0};
    sq.push_back(shadow);
    repeat (4) @(posedge sys_clk);
    reset_n <= 1'b1;
    r = 2'(rnd());
    nx = shadow;
    nx[8][7:6] = r;
    note(nx);
    @(posedge sys_clk);
    {protect_state_hi, protect_state_lo} <= r;
    wr(4'h3, 8'h1F, 1'b1, 1'b1);
    wr(4'h0, 8'h1F, 1'b0, 1'b1);
    wr(4'h0, 8'h00, 1'b1, 1'b1);
    // Back-to-back requests; a short line is refused.
    req(8'h02, 1'b0);
    req(8'h04, 1'b1);
    w = 16'(rnd());
    fe.run_line(10'h015, w, 15, 48, 0, 8'h20);
    cap(10'h015, w, 16, 48, 0, 8'h20, fin(1, 7, {w[7:0], w[15:8]}));
    w = 16'(rnd());
    cap(10'h11C, w, 16, 48, 0, 8'h20, fin(2, 5, {w[7:0], w[15:8]}));
    for (int k = 0; k < 3; k++) begin
      system_625 <= (k == 2);
      req(8'h08, 1'b1);
      w = 16'(rnd());
      cap(cl[k], w, 14, 48, 0, 8'h20, fin(3, 3, copy_map(w[13:0])));
    end
    system_625 <= 1'b0;
    for (int k = 0; k < 6; k++) begin
      req(8'h01, 1'b1);
      asp(al[k], ap[k], av[k], ae[k]);
    end
    req(8'h10, 1'b1);
    w = 16'(rnd());
    fe.run_line(10'h017, w, 14, 48, 0, 8'h20);
    fe.run_line(10'h018, w, 14, 48, 0, 8'h20);
    system_625 <= 1'b1;
    cap(10'h017, w, 14, 48, 0, 8'h20,
        fin(4, 1, {w[7:0], shadow[0][7], 1'b0, w[13:8]}));
    component_input <= 1'b1;
    req(8'h01, 1'b1);
    fe.run_line(10'h010, 16'h0000, 0, 4000, 3125, 8'hA0);
    fe.run_line(10'h011, 16'h0000, 0, 48, 0, 8'h20);
    component_input <= 1'b0;
    system_625 <= 1'b0;
    asp(10'h010, 0, 8'h20, 1'b0);
    // Blanking edges; the last sample above must be taken under the old mode.
    @(posedge sys_clk);
    system_625 <= 1'b1;
    b = 10'h00A + 10'(rnd() % 16);
    blanking_length <= 5'(b);
    ll = '{10'h002, 10'h005, 10'h006, b - 10'h002, b - 10'h001, 10'h064, 10'h137, 10'h13D,
           10'h13E, b + 10'h136, b + 10'h137, 10'h26F, 10'h270};
    for (int k = 0; k < 2; k++) begin
      vbi_passthrough_sel <= k[0];
      foreach (ll[j]) fe.run_line(ll[j], 16'h0000, 0, 48, 0, 8'h20);
    end
    for (int i = 0; i < 50 && sq.size() > 0; i++) @(negedge sys_clk);
    check(80'(sq.size()), 80'h0);
    final_report();
  end
endmodule // tb_vbi_data_request_decoder
